// ===== rtl/picm_device.sv
// Controller pair end: port decode, request and in-service tracking,
// fixed priority, cascade identity broadcast and vector delivery.
// Assumes the acknowledge strobe and request lines are synchronous.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module picm_device (
  picm_link_if.dev link,
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [15:0] irq_in,
  output logic [2:0] cascade_code,
  output logic cascade_drive,
  output logic [1:0] init_busy
);
  logic [1:0] ctrl_int;
  logic [1:0] take;
  logic [7:0] mask_of [2];
  logic [7:0] vec_of [2];
  logic [2:0] lvl_of [2];
  logic [2:0] ident_of [2];
  picm_pkg::picm_ack_e phase_reg;
  logic strobe_prev_reg;
  logic trail;
  logic sec_check_reg;
  logic [2:0] cas_code_reg;
  logic cas_drive_reg;
  logic [7:0] vector_reg;
  logic [7:0] rdata_reg;
  logic intr_reg;
  logic [1:0] rd_hit0;
  logic [1:0] rd_hit1;

  //////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] port_hit(input logic [7:0] addr, input logic sec);
    logic [7:0] even;
    logic [7:0] odd;
    even = sec ? picm_pkg::SEC_BASE : picm_pkg::PRI_BASE;
    odd = sec ? picm_pkg::SEC_ODD : picm_pkg::PRI_ODD;
    port_hit = 2'h0;
    if (addr == even) begin
      port_hit = 2'h1;
    end else if (addr == odd) begin
      port_hit = 2'h2;
    end
  endfunction

  function automatic logic [3:0] first_set(input logic [7:0] v);
    first_set = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        first_set = {1'b1, 3'(i)};
      end
    end
  endfunction

  function automatic logic [7:0] onehot(input logic [2:0] lvl);
    onehot = 8'h01 << lvl;
  endfunction

  //////////////////////////////////////////////////////////////////////
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : ctl
      logic [1:0] hit;
      logic init_go;
      logic busy;
      logic eoi;
      logic [7:0] mask;
      logic [7:0] ident;
      logic [7:0] mode;
      logic [4:0] vbase;
      logic [7:0] lines;
      logic [7:0] elig;
      logic [3:0] req;
      logic [3:0] srv;
      logic [7:0] take_bit;
      logic [7:0] done_bit;
      logic [7:0] edge_reg;
      logic [7:0] pend_reg;
      logic [7:0] serv_reg;

      assign hit = port_hit(link.io_addr, c == 1);

      picm_unit u_picm_unit (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .wr_even(link.io_wr && hit[0]),
        .wr_odd(link.io_wr && hit[1]),
        .wdata(link.io_wdata),
        .init_go(init_go),
        .init_busy(busy),
        .mask_reg(mask),
        .ident_reg(ident),
        .mode_reg(mode),
        .vbase_reg(vbase)
      );

      // The secondary output enters the primary as line 2, so its mask covers all eight.
      if (c == 0) begin : pri
        assign lines = {irq_in[7:3], ctrl_int[1], irq_in[1:0]};
      end else begin : sec
        assign lines = irq_in[15:8];
      end

      assign elig = pend_reg & ~mask;
      assign req = first_set(elig);
      assign srv = first_set(serv_reg);
      // Special nested mode lets a request of the level in service through again.
      assign ctrl_int[c] = req[3] && (!srv[3] || req[2:0] < srv[2:0] ||
                           (mode[picm_pkg::SFNP_BIT] && req[2:0] == srv[2:0]));
      assign eoi = link.io_wr && hit[0] && !link.io_wdata[picm_pkg::INIT_BIT] &&
                   !link.io_wdata[picm_pkg::SEL3_BIT] && link.io_wdata[7:5] == picm_pkg::EOI_CODE;
      assign take_bit = take[c] ? onehot(req[2:0]) : 8'h00;
      assign done_bit = eoi ? onehot(srv[2:0]) : 8'h00;
      assign mask_of[c] = mask;
      assign vec_of[c] = {vbase, req[2:0]};
      assign lvl_of[c] = req[2:0];
      assign ident_of[c] = ident[2:0];
      assign init_busy[c] = busy;

      // Edge memory is forced high at setup so a line must rise afresh.
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          edge_reg <= 8'h00;
        end else if (init_go) begin
          edge_reg <= 8'hff;
        end else begin
          edge_reg <= lines;
        end
      end

      // A new edge wins over a clear in the same cycle.
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          pend_reg <= 8'h00;
        end else begin
          pend_reg <= (lines & ~edge_reg & ~mask) | (pend_reg & ~take_bit & ~{8{init_go}});
        end
      end

      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          serv_reg <= 8'h00;
        end else begin
          serv_reg <= (take_bit & ~{8{mode[picm_pkg::AEOS_BIT]}}) |
                      (serv_reg & ~done_bit & ~{8{init_go}});
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  assign trail = !strobe_prev_reg && link.ack_strobe_n;
  assign take[0] = trail && phase_reg == picm_pkg::ACK_FIRST && ctrl_int[0];
  assign take[1] = sec_check_reg && cas_drive_reg && cas_code_reg == ident_of[1] && ctrl_int[1];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      strobe_prev_reg <= 1'b1;
    end else begin
      strobe_prev_reg <= link.ack_strobe_n;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= picm_pkg::ACK_FIRST;
    end else if (trail) begin
      case (phase_reg)
        picm_pkg::ACK_FIRST: phase_reg <= picm_pkg::ACK_SECOND;
        default: phase_reg <= picm_pkg::ACK_FIRST;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sec_check_reg <= 1'b0;
    end else begin
      sec_check_reg <= trail && phase_reg == picm_pkg::ACK_FIRST;
    end
  end

  // The identity goes out after the first pulse ends and is withdrawn after the second.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cas_code_reg <= 3'h0;
      cas_drive_reg <= 1'b0;
    end else if (trail && phase_reg == picm_pkg::ACK_FIRST) begin
      cas_code_reg <= lvl_of[0];
      cas_drive_reg <= 1'b1;
    end else if (trail) begin
      cas_drive_reg <= 1'b0;
    end
  end

  // The secondary overwrites the primary's vector one cycle later when it is selected.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      vector_reg <= 8'h00;
    end else if (take[0]) begin
      vector_reg <= vec_of[0];
    end else if (take[1]) begin
      vector_reg <= vec_of[1];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      intr_reg <= 1'b0;
    end else begin
      intr_reg <= ctrl_int[0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  assign rd_hit0 = port_hit(link.io_addr, 1'b0);
  assign rd_hit1 = port_hit(link.io_addr, 1'b1);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else if (link.io_rd && rd_hit0[1]) begin
      rdata_reg <= mask_of[0];
    end else if (link.io_rd && rd_hit1[1]) begin
      rdata_reg <= mask_of[1];
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign link.io_rdata = rdata_reg;
  assign link.intr = intr_reg;
  assign link.ack_vector = vector_reg;
  assign link.ack_valid = phase_reg == picm_pkg::ACK_SECOND && !link.ack_strobe_n;
  assign cascade_code = cas_code_reg;
  assign cascade_drive = cas_drive_reg;
endmodule
`default_nettype wire

// ===== rtl/picm_pkg.sv
// Constants, types and register maps shared by the two ends of the
// cascaded interrupt controller pair and by the controller setup unit.
// Assumes a single 200 MHz clock and that both ends share this package.
//
// Behaviour
// - Even-port bit-4 write starts three-word setup
// - Setup start clears that controller's mask
// - Primary cascade word is 04h
// - Primary drives identity between acknowledge trailing edges
// - Secondary identity word is 010b, upper zero
// - Secondary answers only on matching identity
// - Mode word always written, bits 7:5,2 zero
// - Mode bit 4 selects special nested priority
// - Mode bit 3 cleared for non-buffered mode
// - Mode bit 1 selects automatic end of service
// - Mode bit 0 written as one
// - Mask bit one masks, zero unmasks line
// - Masked line never sets its pending bit
// - Primary line 2 mask blocks whole secondary
// - Masking a line leaves other lines working
// - Odd-port read returns mask directly
// - Mask writes ignored while a setup is in progress
// - Mask writable any time once set up
`default_nettype none
package picm_pkg;
  localparam logic [7:0] PRI_BASE = 8'h20;
  localparam logic [7:0] PRI_ODD = 8'h21;
  localparam logic [7:0] SEC_BASE = 8'ha0;
  localparam logic [7:0] SEC_ODD = 8'ha1;
  localparam int INIT_BIT = 4;
  localparam int SFNP_BIT = 4;
  localparam int AEOS_BIT = 1;
  localparam int SEL3_BIT = 3;
  localparam logic [2:0] EOI_CODE = 3'h1;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [7:0] IDENT_RESET = 8'h00;
  localparam logic [4:0] VBASE_RESET = 5'h00;
  localparam logic [7:0] INIT_WORD = 8'h11;
  localparam logic [7:0] PRI_CASCADE_WORD = 8'h04;
  localparam logic [7:0] SEC_ID_WORD = 8'h02;
  localparam logic [7:0] MODE_KEEP = 8'h12;
  localparam logic [7:0] MODE_FORCE = 8'h01;
  localparam int CLK_NS = 5;
  localparam int ACK_LOW_NS = 100;
  localparam int ACK_GAP_NS = 50;
  localparam logic [7:0] ACK_LOW_CYC = 8'((ACK_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] ACK_GAP_CYC = 8'((ACK_GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HR_ADDR = 4'h0;
  localparam logic [3:0] HR_DATA = 4'h1;
  localparam logic [3:0] HR_CTRL = 4'h2;
  localparam logic [3:0] HR_STAT = 4'h3;
  localparam logic [3:0] HR_RDATA = 4'h4;
  localparam logic [3:0] HR_VEC = 4'h5;
  localparam logic [3:0] HR_PVEC = 4'h6;
  localparam logic [3:0] HR_SVEC = 4'h7;
  localparam logic [3:0] HR_MODE = 4'h8;
  localparam int CTRL_RD = 0;
  localparam int CTRL_ACK = 1;
  localparam int CTRL_INIT = 2;
  typedef enum logic [1:0] {INIT_READY, INIT_VEC, INIT_CAS, INIT_MODE} picm_init_e;
  typedef enum logic {ACK_FIRST, ACK_SECOND} picm_ack_e;
  typedef enum logic [2:0] {H_IDLE, H_RDATA, H_INIT, H_ACK1, H_GAP, H_ACK2} picm_host_e;
endpackage
`default_nettype wire

// ===== rtl/picm_link_if.sv
// Link between the processor end and the controller pair: I/O port
// access plus the two-pulse interrupt acknowledge.
// Assumes both ends run on the same clock and sample synchronously.
`timescale 1ns/1ps
`default_nettype none
interface picm_link_if;
  logic [7:0] io_addr;
  logic [7:0] io_wdata;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_rdata;
  logic intr;
  logic ack_strobe_n;
  logic ack_valid;
  logic [7:0] ack_vector;
  modport dev (input io_addr, io_wdata, io_wr, io_rd, ack_strobe_n,
               output io_rdata, intr, ack_valid, ack_vector);
  modport host (output io_addr, io_wdata, io_wr, io_rd, ack_strobe_n,
                input io_rdata, intr, ack_valid, ack_vector);
endinterface
`default_nettype wire

// ===== rtl/picm_unit.sv
// Setup sequencer and configuration words of one controller.
// Assumes even and odd port writes are one-cycle strobes, never together.
`timescale 1ns/1ps
`default_nettype none
module picm_unit (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic wr_even,
  input wire logic wr_odd,
  input wire logic [7:0] wdata,
  output logic init_go,
  output logic init_busy,
  output logic [7:0] mask_reg,
  output logic [7:0] ident_reg,
  output logic [7:0] mode_reg,
  output logic [4:0] vbase_reg
);
  picm_pkg::picm_init_e state_reg;
  logic odd_ok;

  assign init_go = wr_even && wdata[picm_pkg::INIT_BIT];
  assign init_busy = state_reg != picm_pkg::INIT_READY;
  assign odd_ok = wr_odd && !init_go;

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= picm_pkg::INIT_READY;
    end else if (init_go) begin
      state_reg <= picm_pkg::INIT_VEC;
    end else if (wr_odd) begin
      case (state_reg)
        picm_pkg::INIT_VEC: state_reg <= picm_pkg::INIT_CAS;
        picm_pkg::INIT_CAS: state_reg <= picm_pkg::INIT_MODE;
        picm_pkg::INIT_MODE: state_reg <= picm_pkg::INIT_READY;
        default: state_reg <= state_reg;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      vbase_reg <= picm_pkg::VBASE_RESET;
    end else if (odd_ok && state_reg == picm_pkg::INIT_VEC) begin
      vbase_reg <= wdata[7:3];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ident_reg <= picm_pkg::IDENT_RESET;
    end else if (odd_ok && state_reg == picm_pkg::INIT_CAS) begin
      ident_reg <= wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= picm_pkg::MODE_RESET;
    end else if (odd_ok && state_reg == picm_pkg::INIT_MODE) begin
      mode_reg <= wdata;
    end
  end

  // The mask shares the odd port with setup words, so it only listens once idle.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_reg <= picm_pkg::MASK_RESET;
    end else if (init_go) begin
      mask_reg <= picm_pkg::MASK_RESET;
    end else if (odd_ok && state_reg == picm_pkg::INIT_READY) begin
      mask_reg <= wdata;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/picm_host.sv
// Processor end: issues port writes and reads, runs the canonical setup
// sequence and the two-pulse acknowledge on software command.
// Assumes software drives the plain register port synchronously.
`timescale 1ns/1ps
`default_nettype none
module picm_host (
  picm_link_if.host link,
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [3:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata
);
  picm_pkg::picm_host_e state_reg;
  logic [7:0] addr_reg;
  logic [7:0] pvec_reg;
  logic [7:0] svec_reg;
  logic [7:0] mode_opt_reg;
  logic [7:0] mode_word;
  logic [7:0] cnt_reg;
  logic [2:0] step_reg;
  logic [7:0] io_addr_reg;
  logic [7:0] io_wdata_reg;
  logic io_wr_reg;
  logic io_rd_reg;
  logic ack_n_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] vec_reg;
  logic [7:0] sw_rdata_reg;
  logic idle;

  assign idle = state_reg == picm_pkg::H_IDLE;
  assign mode_word = (mode_opt_reg & picm_pkg::MODE_KEEP) | picm_pkg::MODE_FORCE;

  function automatic logic [15:0] init_write(input logic [2:0] step);
    case (step)
      3'h0: init_write = {picm_pkg::PRI_BASE, picm_pkg::INIT_WORD};
      3'h1: init_write = {picm_pkg::PRI_ODD, pvec_reg};
      3'h2: init_write = {picm_pkg::PRI_ODD, picm_pkg::PRI_CASCADE_WORD};
      3'h3: init_write = {picm_pkg::PRI_ODD, mode_word};
      3'h4: init_write = {picm_pkg::SEC_BASE, picm_pkg::INIT_WORD};
      3'h5: init_write = {picm_pkg::SEC_ODD, svec_reg};
      3'h6: init_write = {picm_pkg::SEC_ODD, picm_pkg::SEC_ID_WORD};
      default: init_write = {picm_pkg::SEC_ODD, mode_word};
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_reg <= 8'h00;
      pvec_reg <= 8'h00;
      svec_reg <= 8'h00;
      mode_opt_reg <= 8'h00;
    end else if (sw_wr) begin
      if (sw_addr == picm_pkg::HR_ADDR) begin
        addr_reg <= sw_wdata;
      end else if (sw_addr == picm_pkg::HR_PVEC) begin
        pvec_reg <= sw_wdata;
      end else if (sw_addr == picm_pkg::HR_SVEC) begin
        svec_reg <= sw_wdata;
      end else if (sw_addr == picm_pkg::HR_MODE) begin
        mode_opt_reg <= sw_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_rdata_reg <= 8'h00;
    end else if (!sw_rd) begin
      sw_rdata_reg <= 8'h00;
    end else if (sw_addr == picm_pkg::HR_ADDR) begin
      sw_rdata_reg <= addr_reg;
    end else if (sw_addr == picm_pkg::HR_STAT) begin
      sw_rdata_reg <= {6'h00, link.intr, !idle};
    end else if (sw_addr == picm_pkg::HR_RDATA) begin
      sw_rdata_reg <= rd_data_reg;
    end else if (sw_addr == picm_pkg::HR_VEC) begin
      sw_rdata_reg <= vec_reg;
    end else if (sw_addr == picm_pkg::HR_MODE) begin
      sw_rdata_reg <= mode_word;
    end else begin
      sw_rdata_reg <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Every command is refused while busy, so no mask write can split the setup words.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= picm_pkg::H_IDLE;
      cnt_reg <= 8'h00;
      step_reg <= 3'h0;
      io_addr_reg <= 8'h00;
      io_wdata_reg <= 8'h00;
      io_wr_reg <= 1'b0;
      io_rd_reg <= 1'b0;
      ack_n_reg <= 1'b1;
      rd_data_reg <= 8'h00;
      vec_reg <= 8'h00;
    end else begin
      io_wr_reg <= 1'b0;
      io_rd_reg <= 1'b0;
      case (state_reg)
        picm_pkg::H_IDLE: begin
          if (sw_wr && sw_addr == picm_pkg::HR_DATA) begin
            io_addr_reg <= addr_reg;
            io_wdata_reg <= sw_wdata;
            io_wr_reg <= 1'b1;
          end else if (sw_wr && sw_addr == picm_pkg::HR_CTRL) begin
            if (sw_wdata[picm_pkg::CTRL_INIT]) begin
              step_reg <= 3'h0;
              state_reg <= picm_pkg::H_INIT;
            end else if (sw_wdata[picm_pkg::CTRL_ACK]) begin
              ack_n_reg <= 1'b0;
              cnt_reg <= picm_pkg::ACK_LOW_CYC - 8'h01;
              state_reg <= picm_pkg::H_ACK1;
            end else if (sw_wdata[picm_pkg::CTRL_RD]) begin
              io_addr_reg <= addr_reg;
              io_rd_reg <= 1'b1;
              cnt_reg <= 8'h01;
              state_reg <= picm_pkg::H_RDATA;
            end
          end
        end
        // Port read data appear only in the cycle after the strobe, so one edge passes first.
        picm_pkg::H_RDATA: begin
          if (cnt_reg == 8'h00) begin
            rd_data_reg <= link.io_rdata;
            state_reg <= picm_pkg::H_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        picm_pkg::H_INIT: begin
          {io_addr_reg, io_wdata_reg} <= init_write(step_reg);
          io_wr_reg <= 1'b1;
          step_reg <= step_reg + 3'h1;
          if (step_reg == 3'h7) begin
            state_reg <= picm_pkg::H_IDLE;
          end
        end
        picm_pkg::H_ACK1: begin
          if (cnt_reg == 8'h00) begin
            ack_n_reg <= 1'b1;
            cnt_reg <= picm_pkg::ACK_GAP_CYC - 8'h01;
            state_reg <= picm_pkg::H_GAP;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        picm_pkg::H_GAP: begin
          if (cnt_reg == 8'h00) begin
            ack_n_reg <= 1'b0;
            cnt_reg <= picm_pkg::ACK_LOW_CYC - 8'h01;
            state_reg <= picm_pkg::H_ACK2;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: begin
          if (link.ack_valid) begin
            vec_reg <= link.ack_vector;
          end
          if (cnt_reg == 8'h00) begin
            ack_n_reg <= 1'b1;
            state_reg <= picm_pkg::H_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
      endcase
    end
  end

  assign link.io_addr = io_addr_reg;
  assign link.io_wdata = io_wdata_reg;
  assign link.io_wr = io_wr_reg;
  assign link.io_rd = io_rd_reg;
  assign link.ack_strobe_n = ack_n_reg;
  assign sw_rdata = sw_rdata_reg;
endmodule
`default_nettype wire

// ===== bench/picm_link_checker.sv
// Assertions on the link between the host end and the controller pair.
// Assumes one clock and a testbench that wires the link signals by name.
`timescale 1ns/1ps
`default_nettype none
module picm_link_checker (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic ack_strobe_n,
  input wire logic ack_valid,
  input wire logic [7:0] ack_vector,
  input wire logic [2:0] cascade_code,
  input wire logic cascade_drive,
  input wire logic [1:0] init_busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // A mirror of the primary mask lets reads be judged without the body.
  logic [7:0] mask_reg;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_reg <= 8'h00;
    end else if (io_wr && io_addr == 8'h20 && io_wdata[4]) begin
      mask_reg <= 8'h00;
    end else if (io_wr && io_addr == 8'h21 && !init_busy[0]) begin
      mask_reg <= io_wdata;
    end
  end
  ////////////////////////////////////////
  one_strobe_a: assert property (!(io_wr && io_rd))
    else $error("Both strobes high");
  rdata_idle_a: assert property (!$past(io_rd) |-> io_rdata == 8'h00)
    else $error("Read data outside its cycle");
  mask_read_a: assert property ($past(io_rd && io_addr == 8'h21) |-> io_rdata == mask_reg)
    else $error("Mask read wrong");
  init_start_a: assert property (io_wr && io_addr == 8'h20 && io_wdata[4] |=> init_busy[0])
    else $error("Setup did not start");
  drive_start_a: assert property ($rose(cascade_drive) |-> $past(ack_strobe_n) && !$past(ack_strobe_n, 2))
    else $error("Broadcast began off the trailing edge");
  drive_end_a: assert property ($fell(cascade_drive) |-> $past(ack_strobe_n) && !$past(ack_strobe_n, 2))
    else $error("Broadcast ended off the trailing edge");
  drive_hold_a: assert property (cascade_drive && !ack_strobe_n |=> cascade_drive)
    else $error("Broadcast dropped in a pulse");
  code_hold_a: assert property (cascade_drive && $past(cascade_drive) |-> $stable(cascade_code))
    else $error("Identity code changed");
  valid_window_a: assert property (ack_valid |-> cascade_drive && !ack_strobe_n)
    else $error("Vector valid outside second pulse");
  own_vector_a: assert property (ack_valid && cascade_code != 3'h2 |-> ack_vector[2:0] == cascade_code)
    else $error("Primary vector level wrong");
endmodule
`default_nettype wire

// ===== bench/test_pic_init_and_mask_logic.sv
// Self-checking bench: host end and controller pair joined by the link.
// Assumes software reaches the host only through its register port.
`timescale 1ns/1ps
`default_nettype none
module test_pic_init_and_mask_logic;
  logic ref_clk;
  logic reset_n;
  logic [3:0] sw_addr;
  logic [7:0] sw_wdata;
  logic sw_wr;
  logic sw_rd;
  logic [7:0] sw_rdata;
  logic [15:0] irq_in;
  logic [2:0] cascade_code;
  logic cascade_drive;
  logic [1:0] init_busy;
  logic [7:0] v;
  int mismatches = 0;
  int checked = 0;
  picm_link_if link();
  picm_host u_picm_host (.link(link.host), .ref_clk(ref_clk), .reset_n(reset_n), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  picm_device u_picm_device (.link(link.dev), .ref_clk(ref_clk), .reset_n(reset_n), .irq_in(irq_in),
    .cascade_code(cascade_code), .cascade_drive(cascade_drive), .init_busy(init_busy));
  picm_link_checker u_picm_link_checker (.ref_clk(ref_clk), .reset_n(reset_n), .io_addr(link.io_addr),
    .io_wdata(link.io_wdata), .io_wr(link.io_wr), .io_rd(link.io_rd), .io_rdata(link.io_rdata),
    .ack_strobe_n(link.ack_strobe_n), .ack_valid(link.ack_valid), .ack_vector(link.ack_vector),
    .cascade_code(cascade_code), .cascade_drive(cascade_drive), .init_busy(init_busy));
  ////////////////////////////////////////
  task automatic report_and_stop();
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t ns: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask
  task automatic idle();
    for (int i = 0; i < 100; i++) begin
      rd(picm_pkg::HR_STAT, v);
      if (v[0] === 1'b0) return;
    end
    mismatches++;
    $display("Error at %0t ns: host stuck busy", $time);
    report_and_stop();
  endtask
  task automatic mask_rd(input logic [7:0] port, input logic [7:0] exp);
    wr(picm_pkg::HR_ADDR, port);
    wr(picm_pkg::HR_CTRL, 8'h01);
    idle();
    rd(picm_pkg::HR_RDATA, v);
    check(v, exp);
  endtask
  task automatic mask_wr(input logic [7:0] port, input logic [7:0] val);
    wr(picm_pkg::HR_ADDR, port);
    wr(picm_pkg::HR_DATA, val);
    idle();
  endtask
  task automatic intr_is(input logic exp);
    repeat (4) @(posedge ref_clk);
    rd(picm_pkg::HR_STAT, v);
    check({7'h00, v[1]}, {7'h00, exp});
  endtask
  task automatic ack_is(input logic [7:0] exp);
    wr(picm_pkg::HR_CTRL, 8'h02);
    idle();
    rd(picm_pkg::HR_VEC, v);
    check(v, exp);
  endtask
  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    reset_n = 1'b0;
    sw_addr = 4'h0;
    sw_wdata = 8'h00;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    irq_in = 16'h0000;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    mask_rd(picm_pkg::PRI_ODD, 8'h00);
    rd(4'hf, v);
    check(v, 8'h00);
    mask_wr(picm_pkg::PRI_ODD, 8'hff);
    mask_rd(picm_pkg::PRI_ODD, 8'hff);
    wr(picm_pkg::HR_PVEC, 8'h40);
    wr(picm_pkg::HR_SVEC, 8'h70);
    wr(picm_pkg::HR_MODE, 8'h02);
    rd(picm_pkg::HR_MODE, v);
    check(v, 8'h03);
    wr(picm_pkg::HR_CTRL, 8'h04);
    idle();
    check({6'h00, init_busy}, 8'h00);
    mask_rd(picm_pkg::PRI_ODD, 8'h00);
    mask_rd(picm_pkg::SEC_ODD, 8'h00);
    mask_wr(picm_pkg::SEC_ODD, 8'h5a);
    mask_rd(picm_pkg::SEC_ODD, 8'h5a);
    mask_wr(picm_pkg::SEC_ODD, 8'h00);
    mask_wr(picm_pkg::PRI_ODD, 8'h0c);
    @(posedge ref_clk);
    irq_in <= 16'h0208;
    intr_is(1'b0);
    @(posedge ref_clk);
    irq_in <= 16'h0228;
    intr_is(1'b1);
    ack_is(8'h45);
    mask_wr(picm_pkg::SEC_ODD, 8'h02);
    mask_wr(picm_pkg::PRI_ODD, 8'h00);
    intr_is(1'b0);
    mask_wr(picm_pkg::SEC_ODD, 8'h00);
    intr_is(1'b1);
    ack_is(8'h71);
    report_and_stop();
  end
endmodule
`default_nettype wire
